// file: core/dac_power_txen_defs.vh
/*
  Constants for the DAC power, transmit-enable and protect control slice:
  register offsets, field positions and reset values.
  Assumes inclusion by bare name from core/ design files.
*/
`ifndef DAC_POWER_TXEN_DEFS_VH
`define DAC_POWER_TXEN_DEFS_VH

// Notes on behaviour
// [RQ1] Bits 6..3 power down four channels, reset one
// [RQ2] Bit 2 master bias down disables all channels
// [RQ3] Pair B gate: pin B low powers pair B
// [RQ4] Pair A gate: pin A low powers pair A
// [RQ5] Bits 6,5,3 route sources to protect outputs
// [RQ6] Bit 2 software protect source, reset zero
// [RQ7] Four-bit shared IQ delay, reset code eight
// [RQ8] Delay spans -4 to +3.5, half steps
// [RQ9] Bit 7 selects calibration-ok reporting mode
// [RQ10] Mode one latches rising flag, drives interrupt
// [RQ11] Protect and delay per pair, paged
// [RQ12] Synchronise pins, detect falling edges first

// ****************************************
// Register offsets
// ****************************************
`define ADDR_CHANNEL_POWER_DOWN_CTRL 12'h011
`define ADDR_TX_ENABLE_MASK_CTRL 12'h012
`define ADDR_PROTECT_ROUTING_CTRL 12'h013
`define ADDR_OUTPUT_GROUP_DELAY 12'h014
`define ADDR_IRQ_STATUS_MODE_FIRST 12'h01f

// ****************************************
// Field positions
// ****************************************
`define BIT_PAIR_A_I_PD 6
`define BIT_PAIR_A_Q_PD 5
`define BIT_PAIR_B_I_PD 4
`define BIT_PAIR_B_Q_PD 3
`define BIT_MASTER_BIAS_PD 2
`define BIT_PAIR_B_TXEN_GATE 1
`define BIT_PAIR_A_TXEN_GATE 0
`define BIT_POWER_DETECT_ROUTE 6
`define BIT_TX_PROTECT_ROUTE 5
`define BIT_SW_PROTECT_ROUTE 3
`define BIT_SW_PROTECT 2
`define BIT_CAL_OK_LATCH_MODE 7

// ****************************************
// Reset values and paging codes
// ****************************************
`define RST_CHANNEL_PD 5'h1f
`define RST_TXEN_GATE 2'h0
`define RST_PROTECT_ROUTING 8'h20
`define RST_GROUP_DELAY 4'h8
`define RST_CAL_OK_MODE 1'h0
`define GROUP_DELAY_ZERO 4'h8
`define PAGE_PAIR_B 2'h2
`define PROTECT_ROUTING_MASK 8'h6c
`define RST_CHANNEL_OUT 4'hf
`define RST_HALF_STEPS 4'h0
`define GROUP_DELAY_MSB 3
`define GROUP_DELAY_LSB 0

`endif

// file: core/dac_power_txen_control_regs.v
/*
  Power-down, transmit-enable gating, protect routing, shared IQ group delay
  and calibration-ok reporting mode for a quad DAC.
  Assumes the serial control port decodes frames into one-cycle read and
  write strobes on REF_CLK-synchronous byte ports, and supplies the current
  pair paging code. Transmit-enable and fault pins are asynchronous.
*/
`timescale 1ns/1ps
`include "dac_power_txen_defs.vh"

module dac_power_txen_control_regs #(
  parameter PIN_COUNT = 6
) (
  input wire REF_CLK,
  input wire RST_B,
  input wire [11:0] REG_ADDR,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_WDATA,
  output reg [7:0] REG_RDATA,
  input wire [1:0] PAGE_SEL,
  input wire TRANSMIT_ENABLE_PIN_A,
  input wire TRANSMIT_ENABLE_PIN_B,
  input wire [1:0] POWER_DETECT_FAULT,
  input wire [1:0] TX_PROTECT_FAULT,
  input wire CALIBRATION_OK_FLAG,
  output reg [3:0] CHANNEL_POWERDOWN,
  output reg MASTER_BIAS_POWERDOWN,
  output reg [1:0] PROTECTION_OUTPUT_PINS,
  output reg [3:0] IQ_SHARED_LATENCY_CODE_A,
  output reg [3:0] IQ_SHARED_LATENCY_CODE_B,
  output reg [3:0] LATENCY_HALF_STEPS_A,
  output reg [3:0] LATENCY_HALF_STEPS_B,
  output reg CAL_OK_STATUS,
  output reg IRQ_B
);

  // ****************************************
  // Registers
  // ****************************************
  reg [4:0] channel_pd_reg;
  reg [1:0] txen_gate_reg;
  reg [7:0] protect_a_reg;
  reg [7:0] protect_b_reg;
  reg [3:0] delay_a_reg;
  reg [3:0] delay_b_reg;
  reg cal_ok_mode_reg;
  reg cal_ok_latch_reg;
  reg cal_ok_prev_reg;
  reg [1:0] txen_down_reg;
  reg [PIN_COUNT-1:0] sync1_reg;
  reg [PIN_COUNT-1:0] sync2_reg;
  reg [PIN_COUNT-1:0] sync3_reg;
  reg [PIN_COUNT-1:0] stable_reg;
  reg [7:0] rdata_next;

  wire [PIN_COUNT-1:0] pins_raw;
  wire wr_pair_a;
  wire wr_pair_b;
  wire read_b;
  wire [1:0] txen_stable;
  wire [1:0] txen_fall;
  wire [1:0] txen_rise;
  wire cal_ok_rise;
  wire [7:0] protect_wdata;

  assign pins_raw = {TX_PROTECT_FAULT, POWER_DETECT_FAULT,
                     TRANSMIT_ENABLE_PIN_B, TRANSMIT_ENABLE_PIN_A};
  assign wr_pair_a = PAGE_SEL[0]; // RQ11
  assign wr_pair_b = PAGE_SEL[1]; // RQ11
  assign read_b = (PAGE_SEL == `PAGE_PAIR_B); // RQ11
  assign protect_wdata = REG_WDATA & `PROTECT_ROUTING_MASK;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // A pin change is accepted only once stages two and three agree, which
  // filters a single-cycle metastable resolution.
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g = g + 1) begin : g_sync
      always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
          sync1_reg[g] <= 1'b0;
          sync2_reg[g] <= 1'b0;
          sync3_reg[g] <= 1'b0;
          stable_reg[g] <= 1'b0;
        end else begin
          sync1_reg[g] <= pins_raw[g];
          sync2_reg[g] <= sync1_reg[g];
          sync3_reg[g] <= sync2_reg[g];
          if (sync2_reg[g] == sync3_reg[g]) begin
            stable_reg[g] <= sync3_reg[g]; // RQ12
          end
        end
      end
    end
  endgenerate

  assign txen_stable = stable_reg[1:0];
  // Edge counts only once stages two and three agree on the new level
  assign txen_fall = txen_stable & ~sync3_reg[1:0] & ~sync2_reg[1:0]; // RQ12
  assign txen_rise = ~txen_stable & sync3_reg[1:0] & sync2_reg[1:0]; // RQ12
  assign cal_ok_rise = CALIBRATION_OK_FLAG & ~cal_ok_prev_reg;

  // ****************************************
  // Register writes and event state
  // ****************************************
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      channel_pd_reg <= `RST_CHANNEL_PD;
      txen_gate_reg <= `RST_TXEN_GATE;
      protect_a_reg <= `RST_PROTECT_ROUTING;
      protect_b_reg <= `RST_PROTECT_ROUTING;
      delay_a_reg <= `RST_GROUP_DELAY;
      delay_b_reg <= `RST_GROUP_DELAY;
      cal_ok_mode_reg <= `RST_CAL_OK_MODE;
      cal_ok_latch_reg <= 1'b0;
      cal_ok_prev_reg <= 1'b0;
      txen_down_reg <= 2'h0;
    end else begin
      cal_ok_prev_reg <= CALIBRATION_OK_FLAG;
      if (REG_WR) begin
        case (REG_ADDR)
          `ADDR_CHANNEL_POWER_DOWN_CTRL: begin
            channel_pd_reg <= REG_WDATA[`BIT_PAIR_A_I_PD:`BIT_MASTER_BIAS_PD]; // RQ1
          end
          `ADDR_TX_ENABLE_MASK_CTRL: begin
            txen_gate_reg <= REG_WDATA[`BIT_PAIR_B_TXEN_GATE:`BIT_PAIR_A_TXEN_GATE];
          end
          `ADDR_PROTECT_ROUTING_CTRL: begin
            if (wr_pair_a) begin
              protect_a_reg <= protect_wdata; // RQ11
            end
            if (wr_pair_b) begin
              protect_b_reg <= protect_wdata; // RQ11
            end
          end
          `ADDR_OUTPUT_GROUP_DELAY: begin
            if (wr_pair_a) begin
              delay_a_reg <= REG_WDATA[`GROUP_DELAY_MSB:`GROUP_DELAY_LSB]; // RQ7
            end
            if (wr_pair_b) begin
              delay_b_reg <= REG_WDATA[`GROUP_DELAY_MSB:`GROUP_DELAY_LSB]; // RQ7
            end
          end
          `ADDR_IRQ_STATUS_MODE_FIRST: begin
            cal_ok_mode_reg <= REG_WDATA[`BIT_CAL_OK_LATCH_MODE]; // RQ9
          end
          default: begin
          end
        endcase
      end
      // Set wins over clear; leaving latch mode releases the latch.
      if (cal_ok_mode_reg && cal_ok_rise) begin
        cal_ok_latch_reg <= 1'b1; // RQ10
      end else if (REG_WR && REG_ADDR == `ADDR_IRQ_STATUS_MODE_FIRST
                   && !REG_WDATA[`BIT_CAL_OK_LATCH_MODE]) begin
        cal_ok_latch_reg <= 1'b0;
      end
      // Falling edge arms pair power-down, rising edge releases it.
      if (txen_fall[0]) begin
        txen_down_reg[0] <= 1'b1; // RQ12
      end else if (txen_rise[0]) begin
        txen_down_reg[0] <= 1'b0;
      end
      if (txen_fall[1]) begin
        txen_down_reg[1] <= 1'b1; // RQ12
      end else if (txen_rise[1]) begin
        txen_down_reg[1] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always @* begin
    rdata_next = 8'h00;
    case (REG_ADDR)
      `ADDR_CHANNEL_POWER_DOWN_CTRL: begin
        rdata_next[`BIT_PAIR_A_I_PD:`BIT_MASTER_BIAS_PD] = channel_pd_reg;
      end
      `ADDR_TX_ENABLE_MASK_CTRL: begin
        rdata_next[`BIT_PAIR_B_TXEN_GATE:`BIT_PAIR_A_TXEN_GATE] = txen_gate_reg;
      end
      `ADDR_PROTECT_ROUTING_CTRL: begin
        rdata_next = read_b ? protect_b_reg : protect_a_reg; // RQ11
      end
      `ADDR_OUTPUT_GROUP_DELAY: begin
        rdata_next[`GROUP_DELAY_MSB:`GROUP_DELAY_LSB] = read_b ? delay_b_reg : delay_a_reg; // RQ11
      end
      `ADDR_IRQ_STATUS_MODE_FIRST: begin
        rdata_next[`BIT_CAL_OK_LATCH_MODE] = cal_ok_mode_reg;
      end
      default: begin
        rdata_next = 8'h00;
      end
    endcase
  end

  // ****************************************
  // Outputs
  // ****************************************
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      REG_RDATA <= 8'h00;
      CHANNEL_POWERDOWN <= `RST_CHANNEL_OUT;
      MASTER_BIAS_POWERDOWN <= 1'b1;
      PROTECTION_OUTPUT_PINS <= 2'h0;
      IQ_SHARED_LATENCY_CODE_A <= `RST_GROUP_DELAY;
      IQ_SHARED_LATENCY_CODE_B <= `RST_GROUP_DELAY;
      LATENCY_HALF_STEPS_A <= `RST_HALF_STEPS;
      LATENCY_HALF_STEPS_B <= `RST_HALF_STEPS;
      CAL_OK_STATUS <= 1'b0;
      IRQ_B <= 1'b1;
    end else begin
      if (REG_RD) begin
        REG_RDATA <= rdata_next;
      end
      MASTER_BIAS_POWERDOWN <= channel_pd_reg[0]; // RQ2
      // Channel order: [3] A-I, [2] A-Q, [1] B-I, [0] B-Q.
      CHANNEL_POWERDOWN[3] <= channel_pd_reg[4] | channel_pd_reg[0]
                              | (txen_gate_reg[0] & txen_down_reg[0]); // RQ4
      CHANNEL_POWERDOWN[2] <= channel_pd_reg[3] | channel_pd_reg[0]
                              | (txen_gate_reg[0] & txen_down_reg[0]); // RQ4
      CHANNEL_POWERDOWN[1] <= channel_pd_reg[2] | channel_pd_reg[0]
                              | (txen_gate_reg[1] & txen_down_reg[1]); // RQ3
      CHANNEL_POWERDOWN[0] <= channel_pd_reg[1] | channel_pd_reg[0]
                              | (txen_gate_reg[1] & txen_down_reg[1]); // RQ3
      PROTECTION_OUTPUT_PINS[0] <=
        (protect_a_reg[`BIT_POWER_DETECT_ROUTE] & stable_reg[2])
        | (protect_a_reg[`BIT_TX_PROTECT_ROUTE] & stable_reg[4])
        | (protect_a_reg[`BIT_SW_PROTECT_ROUTE] & protect_a_reg[`BIT_SW_PROTECT]); // RQ5 RQ6
      PROTECTION_OUTPUT_PINS[1] <=
        (protect_b_reg[`BIT_POWER_DETECT_ROUTE] & stable_reg[3])
        | (protect_b_reg[`BIT_TX_PROTECT_ROUTE] & stable_reg[5])
        | (protect_b_reg[`BIT_SW_PROTECT_ROUTE] & protect_b_reg[`BIT_SW_PROTECT]); // RQ5 RQ6
      IQ_SHARED_LATENCY_CODE_A <= delay_a_reg; // RQ7
      IQ_SHARED_LATENCY_CODE_B <= delay_b_reg; // RQ7
      // Two's complement half periods: code 0 is -8 (-4 clocks), 15 is +7.
      LATENCY_HALF_STEPS_A <= delay_a_reg ^ `GROUP_DELAY_ZERO; // RQ8
      LATENCY_HALF_STEPS_B <= delay_b_reg ^ `GROUP_DELAY_ZERO; // RQ8
      CAL_OK_STATUS <= cal_ok_mode_reg ? cal_ok_latch_reg : CALIBRATION_OK_FLAG; // RQ10
      IRQ_B <= ~(cal_ok_mode_reg & cal_ok_latch_reg); // RQ10
    end
  end

endmodule

// file: tb/dac_power_txen_chk.sv
/* Port-level checker for the power, enable and protect register slice.
   Assumes binding to the register module; it watches that module's ports only. */
`timescale 1ns/1ps
module dac_power_txen_chk (
  input wire REF_CLK,
  input wire RST_B,
  input wire REG_WR,
  input wire REG_RD,
  input wire CALIBRATION_OK_FLAG,
  input wire [11:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire [7:0] REG_RDATA,
  input wire [1:0] PAGE_SEL,
  input wire [1:0] POWER_DETECT_FAULT,
  input wire [1:0] TX_PROTECT_FAULT,
  input wire [1:0] PROTECTION_OUTPUT_PINS,
  input wire TRANSMIT_ENABLE_PIN_B,
  input wire MASTER_BIAS_POWERDOWN,
  input wire CAL_OK_STATUS,
  input wire IRQ_B,
  input wire [3:0] CHANNEL_POWERDOWN,
  input wire [3:0] IQ_SHARED_LATENCY_CODE_A,
  input wire [3:0] LATENCY_HALF_STEPS_A
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  bias_forces_a: assert property (MASTER_BIAS_POWERDOWN |-> CHANNEL_POWERDOWN == 4'hf)
    else $error("bias down without all channels down");
  half_step_a: assert property (LATENCY_HALF_STEPS_A == IQ_SHARED_LATENCY_CODE_A - 4'h8)
    else $error("half steps not code minus eight");
  delay_write_a: assert property (REG_WR && REG_ADDR == 12'h014 && PAGE_SEL[0]
    |-> ##2 IQ_SHARED_LATENCY_CODE_A == $past(REG_WDATA[3:0], 2)) else $error("delay code lost");
  route_mask_a: assert property (REG_RD && REG_ADDR == 12'h013 |=> (REG_RDATA & 8'h93) == 8'h00)
    else $error("reserved routing bits read high");
  rdata_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA)) else $error("read data moved");
  irq_latch_a: assert property (!IRQ_B |-> CAL_OK_STATUS) else $error("irq without status");
  irq_cause_a: assert property ($fell(IRQ_B) |-> $past(CALIBRATION_OK_FLAG, 2))
    else $error("irq fell without flag");
  pair_b_down_a: assert property ($rose(CHANNEL_POWERDOWN[1]) && !MASTER_BIAS_POWERDOWN
    |-> !$past(TRANSMIT_ENABLE_PIN_B, 4) || $past(REG_WR, 2)) else $error("pair b down uncaused");
  protect_cause_a: assert property ($rose(PROTECTION_OUTPUT_PINS[0]) |-> $past(REG_WR, 2)
    || $past(POWER_DETECT_FAULT[0], 4) || $past(TX_PROTECT_FAULT[0], 4))
    else $error("protect uncaused");
  cover property (!IRQ_B);
  cover property ($rose(PROTECTION_OUTPUT_PINS[0]));
  cover property (CHANNEL_POWERDOWN == 4'hc && !MASTER_BIAS_POWERDOWN);
endmodule
bind dac_power_txen_control_regs dac_power_txen_chk chk (.*);

// file: tb/txen_host_model.sv
/* Host driving the two transmit-enable pins, asynchronous to the device.
   Assumes the bench gives wanted levels; slow adds a lag of two cycles. */
`timescale 1ns/1ps
module txen_host_model (
  input wire clk,
  input wire slow,
  input wire want_a,
  input wire want_b,
  output reg pin_a = 1'h1,
  output reg pin_b = 1'h1
);
  reg [1:0] lag_a = 2'h3, lag_b = 2'h3;
  // Pins move on the falling edge so the device synchroniser sees real skew
  always @(negedge clk) begin
    lag_a <= {lag_a[0], want_a};
    lag_b <= {lag_b[0], want_b};
    pin_a <= slow ? lag_a[1] : want_a;
    pin_b <= slow ? lag_b[1] : want_b;
  end
endmodule

// file: tb/dac_power_txen_control_regs_bench.sv
/* Self-checking bench for the power, enable and protect register slice.
   Assumes the host model on the enable pins and the bound port checker. */
`timescale 1ns/1ps
module dac_power_txen_control_regs_bench;
  reg REF_CLK = 0, RST_B = 0, REG_WR = 0, REG_RD = 0, CALIBRATION_OK_FLAG = 0;
  reg wa = 1, wb = 1, slow = 0;
  reg [11:0] REG_ADDR = 0;
  reg [7:0] REG_WDATA = 0;
  reg [1:0] PAGE_SEL = 2'h3, POWER_DETECT_FAULT = 0, TX_PROTECT_FAULT = 0;
  wire TRANSMIT_ENABLE_PIN_A, TRANSMIT_ENABLE_PIN_B;
  wire MASTER_BIAS_POWERDOWN, CAL_OK_STATUS, IRQ_B;
  wire [7:0] REG_RDATA;
  wire [1:0] PROTECTION_OUTPUT_PINS;
  wire [3:0] CHANNEL_POWERDOWN, IQ_SHARED_LATENCY_CODE_A, IQ_SHARED_LATENCY_CODE_B;
  wire [3:0] LATENCY_HALF_STEPS_A, LATENCY_HALF_STEPS_B;
  int n_errors = 0, cmp_count = 0, cyc = 0;
  dac_power_txen_control_regs uut (.*);
  txen_host_model host (.clk(REF_CLK), .slow(slow), .want_a(wa), .want_b(wb),
    .pin_a(TRANSMIT_ENABLE_PIN_A), .pin_b(TRANSMIT_ENABLE_PIN_B));
  always #2 REF_CLK = ~REF_CLK;
  // Ceiling well above the few hundred cycles the scenarios need
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end
  task summarize();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input [7:0] g, input [7:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task w(input int n);
    repeat (n) @(posedge REF_CLK);
    @(negedge REF_CLK);
  endtask
  task wr(input [11:0] a, input [7:0] d, input [1:0] p);
    @(posedge REF_CLK);
    REG_ADDR <= a; REG_WDATA <= d; PAGE_SEL <= p; REG_WR <= 1;
    @(posedge REF_CLK);
    REG_WR <= 0;
  endtask
  task rd(input [11:0] a, input [1:0] p, input [7:0] e);
    @(posedge REF_CLK);
    REG_ADDR <= a; PAGE_SEL <= p; REG_RD <= 1;
    @(posedge REF_CLK);
    REG_RD <= 0;
    w(1);
    chk(REG_RDATA, e);
  endtask
  task t_reset();
    chk(CHANNEL_POWERDOWN, 8'h0f);
    chk(MASTER_BIAS_POWERDOWN, 8'h01);
    rd(12'h011, 2'h3, 8'h7c);
    rd(12'h012, 2'h3, 8'h00);
    rd(12'h013, 2'h2, 8'h20);
    rd(12'h014, 2'h2, 8'h08);
    rd(12'h01f, 2'h3, 8'h00);
    rd(12'h000, 2'h3, 8'h00);
  endtask
  task t_power();
    wr(12'h011, 8'h50, 2'h3);
    w(2); chk(CHANNEL_POWERDOWN, 8'h0a);
    chk(MASTER_BIAS_POWERDOWN, 8'h00);
    wr(12'h011, 8'h04, 2'h3);
    w(2); chk(CHANNEL_POWERDOWN, 8'h0f);
    wr(12'h011, 8'h00, 2'h3);
    w(2); chk(CHANNEL_POWERDOWN, 8'h00);
  endtask
  task t_txen();
    wr(12'h012, 8'h01, 2'h3);
    wa <= 0; wb <= 0;
    w(8); chk(CHANNEL_POWERDOWN, 8'h0c);
    wa <= 1; wb <= 1; slow <= 1;
    w(10); chk(CHANNEL_POWERDOWN, 8'h00);
    wr(12'h012, 8'h03, 2'h3);
    wb <= 0;
    w(10); chk(CHANNEL_POWERDOWN, 8'h03);
    wb <= 1;
    w(10); chk(CHANNEL_POWERDOWN, 8'h00);
  endtask
  task t_protect();
    wr(12'h013, 8'h64, 2'h1);
    wr(12'h013, 8'hff, 2'h2);
    rd(12'h013, 2'h2, 8'h6c);
    rd(12'h013, 2'h3, 8'h64);
    w(1); chk(PROTECTION_OUTPUT_PINS, 8'h02);
    @(posedge REF_CLK);
    TX_PROTECT_FAULT <= 2'h1;
    w(8); chk(PROTECTION_OUTPUT_PINS, 8'h03);
    @(posedge REF_CLK);
    TX_PROTECT_FAULT <= 2'h0;
    wr(12'h013, 8'h00, 2'h2);
    w(8); chk(PROTECTION_OUTPUT_PINS, 8'h00);
    wr(12'h013, 8'h40, 2'h2);
    POWER_DETECT_FAULT <= 2'h2;
    w(8);
    chk(PROTECTION_OUTPUT_PINS, 8'h02);
    @(posedge REF_CLK);
    POWER_DETECT_FAULT <= 2'h0;
    w(8);
    chk(PROTECTION_OUTPUT_PINS, 8'h00);
  endtask
  task t_delay();
    reg [3:0] h;
    for (int i = 0; i < 16; i++) begin
      h = i - 8;
      wr(12'h014, i, 2'h3);
      w(2); chk(IQ_SHARED_LATENCY_CODE_B, i);
      chk(IQ_SHARED_LATENCY_CODE_A, i);
      chk(LATENCY_HALF_STEPS_A, h);
      chk(LATENCY_HALF_STEPS_B, h);
    end
    wr(12'h014, 8'h03, 2'h1);
    w(2);
    chk(IQ_SHARED_LATENCY_CODE_A, 8'h03);
    chk(IQ_SHARED_LATENCY_CODE_B, 8'h0f);
    rd(12'h014, 2'h2, 8'h0f);
  endtask
  task t_cal();
    wr(12'h01f, 8'h80, 2'h3);
    CALIBRATION_OK_FLAG <= 1;
    @(posedge REF_CLK) CALIBRATION_OK_FLAG <= 0;
    w(3); chk({IRQ_B, CAL_OK_STATUS}, 8'h01);
    rd(12'h01f, 2'h3, 8'h80);
    wr(12'h01f, 8'h00, 2'h3);
    w(3); chk({IRQ_B, CAL_OK_STATUS}, 8'h02);
    @(posedge REF_CLK);
    CALIBRATION_OK_FLAG <= 1;
    w(2); chk({IRQ_B, CAL_OK_STATUS}, 8'h03);
    @(posedge REF_CLK);
    CALIBRATION_OK_FLAG <= 0;
  endtask
  // Second reset in mid-run must restore power-down, both delay codes, IRQ and status, and pair A routing
  task t_rerun();
    @(posedge REF_CLK);
    RST_B <= 0;
    repeat (5) @(posedge REF_CLK);
    RST_B <= 1;
    w(1);
    chk(CHANNEL_POWERDOWN, 8'h0f);
    chk(MASTER_BIAS_POWERDOWN, 8'h01);
    chk(IQ_SHARED_LATENCY_CODE_A, 8'h08);
    chk(IQ_SHARED_LATENCY_CODE_B, 8'h08);
    chk({IRQ_B, CAL_OK_STATUS}, 8'h02);
    rd(12'h013, 2'h1, 8'h20);
  endtask
  initial begin
    repeat (5) @(posedge REF_CLK);
    RST_B <= 1;
    w(1);
    t_reset(); t_power(); t_txen(); t_protect(); t_delay(); t_cal();
    t_rerun();
    summarize();
  end
endmodule
